// [design/tc8_pkg.sv]
package tc8_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus geometry
  localparam int unsigned IDX_W = 7;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL = 7'h44;
  localparam logic [IDX_W-1:0] IDX_MASK = 7'h6E;
  localparam logic [IDX_W-1:0] IDX_COUNT = 7'h50;
  localparam logic [IDX_W-1:0] IDX_CMP = 7'h51;
  localparam logic [IDX_W-1:0] IDX_FLAG = 7'h52;
  localparam logic [IDX_W-1:0] IDX_AUX = 7'h53;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned CTRL_FORCE_BIT = 7;
  localparam int unsigned CTRL_WAVE_LO_BIT = 6;
  localparam int unsigned CTRL_ACT_HI_BIT = 5;
  localparam int unsigned CTRL_ACT_LO_BIT = 4;
  localparam int unsigned CTRL_WAVE_HI_BIT = 3;
  localparam int unsigned CTRL_CS_HI_BIT = 2;
  localparam int unsigned CTRL_CS_LO_BIT = 0;

  // Mask, flag and auxiliary register fields
  localparam int unsigned CMP_BIT = 1;
  localparam int unsigned OVF_BIT = 0;
  localparam int unsigned AUX_DIR_BIT = 0;
  localparam int unsigned AUX_GIE_BIT = 1;
  localparam logic [REG_W-1:0] MASK_USED = 8'h03;
  localparam logic [REG_W-1:0] AUX_USED = 8'h03;

  // Reset values
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
  localparam logic [REG_W-1:0] MASK_RST = 8'h00;
  localparam logic [REG_W-1:0] COUNT_RST = 8'h00;
  localparam logic [REG_W-1:0] CMP_RST = 8'h00;
  localparam logic [REG_W-1:0] AUX_RST = 8'h00;
  localparam logic [1:0] FLAG_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Wave modes, output actions, clock selects
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CLEAR_MATCH = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;

  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler: tap fires when the low bits are all ones
  localparam int unsigned PRE_W = 10;
  localparam logic [PRE_W-1:0] TAP_8 = 10'h007;
  localparam logic [PRE_W-1:0] TAP_64 = 10'h03F;
  localparam logic [PRE_W-1:0] TAP_256 = 10'h0FF;
  localparam logic [PRE_W-1:0] TAP_1024 = 10'h3FF;

  // Counter end points
  localparam logic [REG_W-1:0] COUNT_MAX = 8'hFF;
  localparam logic [REG_W-1:0] COUNT_BOTTOM = 8'h00;
  localparam logic [REG_W-1:0] COUNT_ONE = 8'h01;
  localparam logic [REG_W-1:0] COUNT_BELOW_MAX = 8'hFE;

endpackage

// [design/tc8_reg_if.sv]
`timescale 1ns/1ns
// Register access between the bus slave and the timer core
interface tc8_reg_if;
  logic wr;
  logic [tc8_pkg::IDX_W-1:0] idx;
  logic [tc8_pkg::REG_W-1:0] wdata;
  logic [tc8_pkg::REG_W-1:0] rdata;
  modport bus (output wr, output idx, output wdata, input rdata);
  modport core (input wr, input idx, input wdata, output rdata);
endinterface

// [design/tc8_tick.sv]
`timescale 1ns/1ns
module tc8_tick (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Source choice and pin
  input wire logic [2:0] cs_i,
  input wire logic ext_pin_i,
  // One-cycle count enable
  output logic tick_o
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [tc8_pkg::PRE_W-1:0] pre_r;
  wire rise = sync2_r & ~prev_r;
  wire fall = ~sync2_r & prev_r;
  wire tap8 = (pre_r & tc8_pkg::TAP_8) == tc8_pkg::TAP_8;
  wire tap64 = (pre_r & tc8_pkg::TAP_64) == tc8_pkg::TAP_64;
  wire tap256 = (pre_r & tc8_pkg::TAP_256) == tc8_pkg::TAP_256;
  wire tap1024 = pre_r == tc8_pkg::TAP_1024;

  // Free-running prescaler; pin sampled even when driven by us
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= '0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 10'h001;
      sync1_r <= ext_pin_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Source select: a single-cycle enable, never a clock
  always_comb begin
    case (cs_i)
      tc8_pkg::CS_STOP: tick_o = 1'b0;
      tc8_pkg::CS_DIV1: tick_o = 1'b1;
      tc8_pkg::CS_DIV8: tick_o = tap8;
      tc8_pkg::CS_DIV64: tick_o = tap64;
      tc8_pkg::CS_DIV256: tick_o = tap256;
      tc8_pkg::CS_DIV1024: tick_o = tap1024;
      tc8_pkg::CS_EXT_FALL: tick_o = fall;
      tc8_pkg::CS_EXT_RISE: tick_o = rise;
      default: tick_o = 1'b0;
    endcase
  end

endmodule

// [design/tc8_wb.sv]
`timescale 1ns/1ns
module tc8_wb (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [8:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core side
  tc8_reg_if.bus regs
);

  logic ack_r;
  logic [31:0] dat_r;
  wire req = cyc_i & stb_i;
  wire first = req & ~ack_r;

  // Write lands on the edge where the master sees ack
  assign regs.idx = adr_i;
  assign regs.wdata = dat_i[7:0];
  assign regs.wr = req & we_i & sel_i[0] & ack_r;
  assign dat_o = dat_r;
  assign ack_o = ack_r;

  // One wait cycle; unmapped reads return zero from the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= first;
      if (first) begin
        dat_r <= {24'h000000, regs.rdata};
      end
    end
  end

endmodule

// [design/tc8_timer.sv]
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
module tc8_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic external_count_pin_i,
  input wire logic port_data_i,
  output logic wave_output_pin_o,
  output logic wave_output_pin_oe_o,
  // Interrupt requests and vector acknowledges
  input wire logic compare_vec_taken_i,
  input wire logic overflow_vec_taken_i,
  output logic compare_irq_o,
  output logic overflow_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  // Slave and core share one register port
  tc8_reg_if regs ();

  tc8_wb u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(wb_cyc_i),
    .stb_i(wb_stb_i),
    .we_i(wb_we_i),
    .adr_i(wb_adr_i),
    .sel_i(wb_sel_i),
    .dat_i(wb_dat_i),
    .dat_o(wb_dat_o),
    .ack_o(wb_ack_o),
    .regs(regs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  // Software-visible registers
  logic [7:0] ctrl_r;
  logic [7:0] mask_r;
  logic [7:0] aux_r;
  // Counter and its compare buffer
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] cmp_r;
  logic [7:0] cmp_act_r;
  // Flags, slope direction, write block, strobe
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;
  logic dir_r;
  logic dir_nxt;
  logic block_r;
  logic force_r;
  // Waveform state, pin and request flops
  logic wave_r;
  logic wave_nxt;
  logic pin_r;
  logic oe_r;
  logic cmp_irq_r;
  logic ovf_irq_r;
  // Events decoded in this cycle
  logic ovf_ev;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // Timer tick source

  tc8_tick u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cs_i(ctrl_r[tc8_pkg::CTRL_CS_HI_BIT:tc8_pkg::CTRL_CS_LO_BIT]),
    .ext_pin_i(external_count_pin_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Register selects
  wire wr_ctrl = regs.wr && regs.idx == tc8_pkg::IDX_CTRL;
  wire wr_mask = regs.wr && regs.idx == tc8_pkg::IDX_MASK;
  wire wr_count = regs.wr && regs.idx == tc8_pkg::IDX_COUNT;
  wire wr_cmp = regs.wr && regs.idx == tc8_pkg::IDX_CMP;
  wire wr_flag = regs.wr && regs.idx == tc8_pkg::IDX_FLAG;
  wire wr_aux = regs.wr && regs.idx == tc8_pkg::IDX_AUX;

  // Mode and action fields
  wire [1:0] mode = {ctrl_r[tc8_pkg::CTRL_WAVE_HI_BIT],
                     ctrl_r[tc8_pkg::CTRL_WAVE_LO_BIT]};
  wire [1:0] act = ctrl_r[tc8_pkg::CTRL_ACT_HI_BIT:tc8_pkg::CTRL_ACT_LO_BIT];
  wire immediate = mode == tc8_pkg::MODE_NORMAL || mode == tc8_pkg::MODE_CLEAR_MATCH;

  // Counter landmarks
  wire at_max = count_r == tc8_pkg::COUNT_MAX;
  wire at_bottom = count_r == tc8_pkg::COUNT_BOTTOM;
  wire is_eq = count_r == cmp_act_r;
  // Limitation: a count write of the compare value itself costs that
  // period its match, since the block spans the whole next tick
  wire match = tick && is_eq && !block_r;
  wire top_case = act[1] && cmp_act_r == tc8_pkg::COUNT_MAX;
  wire up_cnt = !dir_r || at_bottom;

  // Force accepted only when the written mode is non-PWM (low mode bit clear)
  wire force_req = wr_ctrl && regs.wdata[tc8_pkg::CTRL_FORCE_BIT]
                   && !regs.wdata[tc8_pkg::CTRL_WAVE_LO_BIT];

  // Compare double buffer: immediate, or at the MAX tick in PWM modes
  // Deferring the load keeps one compare value per PWM period, so no glitch
  wire cmp_load = immediate || (tick && at_max);

  // Flag clears: software one, or vector taken
  wire [1:0] flag_clr = (wr_flag ? regs.wdata[1:0] : 2'b00)
                        | {compare_vec_taken_i, overflow_vec_taken_i};
  // Only real events raise flags; the forced match never reaches here
  wire [1:0] flag_set = {match, ovf_ev};

  // Read back; force strobe never stored, unmapped reads zero
  assign regs.rdata =
    (regs.idx == tc8_pkg::IDX_CTRL) ? ctrl_r :
    (regs.idx == tc8_pkg::IDX_MASK) ? mask_r :
    (regs.idx == tc8_pkg::IDX_COUNT) ? count_r :
    (regs.idx == tc8_pkg::IDX_CMP) ? cmp_r :
    (regs.idx == tc8_pkg::IDX_FLAG) ? {6'h00, flag_r} :
    (regs.idx == tc8_pkg::IDX_AUX) ? aux_r :
    8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Counter sequence

  // Single clock throughout; tick only gates the step
  always_comb begin
    count_nxt = count_r;
    dir_nxt = (mode == tc8_pkg::MODE_PHASE) ? dir_r : 1'b0;
    ovf_ev = 1'b0;
    if (tick) begin
      case (mode)
        tc8_pkg::MODE_NORMAL, tc8_pkg::MODE_FAST: begin
          count_nxt = count_r + tc8_pkg::COUNT_ONE;
          ovf_ev = at_max;
        end
        tc8_pkg::MODE_CLEAR_MATCH: begin
          // TOP is the compare value; a blocked match does not wrap
          if (match) begin
            count_nxt = tc8_pkg::COUNT_BOTTOM;
          end else begin
            count_nxt = count_r + tc8_pkg::COUNT_ONE;
          end
          ovf_ev = at_max;
        end
        // Dual slope: MAX and BOTTOM each hold for one tick
        tc8_pkg::MODE_PHASE: begin
          if (!dir_r) begin
            if (at_max) begin
              dir_nxt = 1'b1;
              count_nxt = tc8_pkg::COUNT_BELOW_MAX;
            end else begin
              count_nxt = count_r + tc8_pkg::COUNT_ONE;
            end
          end else if (at_bottom) begin
            dir_nxt = 1'b0;
            count_nxt = tc8_pkg::COUNT_ONE;
            ovf_ev = 1'b1;
          end else begin
            count_nxt = count_r - tc8_pkg::COUNT_ONE;
          end
        end
        default: begin
          count_nxt = count_r;
        end
      endcase
    end
    // Software write replaces the count outright
    if (wr_count) begin
      count_nxt = regs.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform generator

  // Forced match touches only the wave, never flags or the counter
  always_comb begin
    wave_nxt = wave_r;
    case (mode)
      tc8_pkg::MODE_NORMAL, tc8_pkg::MODE_CLEAR_MATCH: begin
        if (match || force_r) begin
          case (act)
            tc8_pkg::ACT_TOGGLE: wave_nxt = ~wave_r;
            tc8_pkg::ACT_CLEAR: wave_nxt = 1'b0;
            tc8_pkg::ACT_SET: wave_nxt = 1'b1;
            default: wave_nxt = wave_r;
          endcase
        end
      end
      tc8_pkg::MODE_FAST: begin
        // Action 01 is reserved and does nothing
        if (act[1]) begin
          if (tick && at_max) begin
            wave_nxt = ~act[0];
          end else if (match && !top_case) begin
            wave_nxt = act[0];
          end
        end
      end
      tc8_pkg::MODE_PHASE: begin
        if (act[1]) begin
          if (top_case) begin
            if (tick && at_max) begin
              wave_nxt = ~act[0];
            end
          end else if (match) begin
            // A match at BOTTOM counts as up so the output stays flat
            wave_nxt = up_cnt ? act[0] : ~act[0];
          end
        end
      end
      default: begin
        wave_nxt = wave_r;
      end
    endcase
  end

  // Hardware set beats a simultaneous clear
  // so a match in the clearing cycle is never lost
  assign flag_nxt = (flag_r & ~flag_clr) | flag_set;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= tc8_pkg::CTRL_RST;
      mask_r <= tc8_pkg::MASK_RST;
      aux_r <= tc8_pkg::AUX_RST;
      cmp_r <= tc8_pkg::CMP_RST;
      force_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= regs.wdata & ~(8'h01 << tc8_pkg::CTRL_FORCE_BIT);
      end
      if (wr_mask) begin
        mask_r <= regs.wdata & tc8_pkg::MASK_USED;
      end
      if (wr_aux) begin
        aux_r <= regs.wdata & tc8_pkg::AUX_USED;
      end
      if (wr_cmp) begin
        cmp_r <= regs.wdata;
      end
      // Strobe lives one cycle and is never stored in the register
      force_r <= force_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, compare buffer and flags

  // Block lasts from a counter write until the next tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= tc8_pkg::COUNT_RST;
      dir_r <= 1'b0;
      cmp_act_r <= tc8_pkg::CMP_RST;
      flag_r <= tc8_pkg::FLAG_RST;
      block_r <= 1'b0;
      wave_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      dir_r <= dir_nxt;
      if (cmp_load) begin
        cmp_act_r <= cmp_r;
      end
      flag_r <= flag_nxt;
      // A write that meets a tick still blocks the tick after it
      if (wr_count) begin
        block_r <= 1'b1;
      end else if (tick) begin
        block_r <= 1'b0;
      end
      wave_r <= wave_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and interrupt outputs

  // Registered so the pins never glitch on decode changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_r <= 1'b0;
      oe_r <= 1'b0;
      cmp_irq_r <= 1'b0;
      ovf_irq_r <= 1'b0;
    end else begin
      // Port value passes while the action field is off
      pin_r <= (act != tc8_pkg::ACT_OFF) ? wave_r : port_data_i;
      oe_r <= aux_r[tc8_pkg::AUX_DIR_BIT];
      cmp_irq_r <= mask_r[tc8_pkg::CMP_BIT] && flag_r[tc8_pkg::CMP_BIT]
                   && aux_r[tc8_pkg::AUX_GIE_BIT];
      ovf_irq_r <= mask_r[tc8_pkg::OVF_BIT] && flag_r[tc8_pkg::OVF_BIT]
                   && aux_r[tc8_pkg::AUX_GIE_BIT];
    end
  end

  // Outputs straight from their flops
  assign wave_output_pin_o = pin_r;
  assign wave_output_pin_oe_o = oe_r;
  assign compare_irq_o = cmp_irq_r;
  assign overflow_irq_o = ovf_irq_r;

endmodule

// [bench/tc8_timer_properties.sv]
`timescale 1ns/1ns
module tc8_timer_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and requests
  input wire logic port_data_i,
  input wire logic wave_output_pin_o,
  input wire logic wave_output_pin_oe_o,
  input wire logic compare_irq_o,
  input wire logic overflow_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Finished transfers, seen at the ack edge
  wire req = wb_cyc_i && wb_stb_i;
  wire wr_ok = req && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire rd_ok = req && !wb_we_i && wb_ack_o;
  wire aux_wr = wr_ok && wb_adr_i == tc8_pkg::IDX_AUX;
  ////////////////////////////////////////
  ack_wait_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_idle_a: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  read_high_a: assert property (rd_ok |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  force_read_a: assert property (rd_ok && wb_adr_i == tc8_pkg::IDX_CTRL |->
    !wb_dat_o[tc8_pkg::CTRL_FORCE_BIT]) else $error("force bit read as one");
  mask_read_a: assert property (rd_ok && wb_adr_i == tc8_pkg::IDX_MASK |->
    (wb_dat_o[7:0] & ~tc8_pkg::MASK_USED) == 8'h00) else $error("mask spare bits set");
  dir_enable_a: assert property (aux_wr |-> ##2
    wave_output_pin_oe_o == $past(wb_dat_i[tc8_pkg::AUX_DIR_BIT], 2))
    else $error("driver enable wrong");
  gie_gate_a: assert property (aux_wr && !wb_dat_i[tc8_pkg::AUX_GIE_BIT] |->
    ##3 !compare_irq_o && !overflow_irq_o) else $error("request without global enable");
  mask_gate_a: assert property (wr_ok && wb_adr_i == tc8_pkg::IDX_MASK &&
    wb_dat_i[1:0] == 2'h0 |-> ##3 !compare_irq_o && !overflow_irq_o)
    else $error("request while masked");
  port_pass_a: assert property (wr_ok && wb_adr_i == tc8_pkg::IDX_CTRL &&
    wb_dat_i[5:4] == 2'h0 |-> ##3 wave_output_pin_o == $past(port_data_i))
    else $error("port value not on pin");
endmodule

bind tc8_timer tc8_timer_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .port_data_i(port_data_i), .wave_output_pin_o(wave_output_pin_o),
  .wave_output_pin_oe_o(wave_output_pin_oe_o), .compare_irq_o(compare_irq_o),
  .overflow_irq_o(overflow_irq_o));

// [bench/tc8_timer_tb.sv]
`timescale 1ns/1ns
module tc8_timer_tb;
  // Short aliases of the register indices
  localparam logic [6:0] CT = tc8_pkg::IDX_CTRL;
  localparam logic [6:0] MK = tc8_pkg::IDX_MASK;
  localparam logic [6:0] CN = tc8_pkg::IDX_COUNT;
  localparam logic [6:0] CP = tc8_pkg::IDX_CMP;
  localparam logic [6:0] FL = tc8_pkg::IDX_FLAG;
  localparam logic [6:0] AX = tc8_pkg::IDX_AUX;
  // Stimulus, observed outputs, tallies
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:2] adr = 7'h00;
  logic [31:0] wdat = 32'h00000000;
  logic ext = 1'b0;
  logic pdat = 1'b0;
  logic cvec = 1'b0;
  logic ovec = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [3:0] sel_use = 4'h1;
  logic [31:0] rdat;
  logic ack, pin, oe, cirq, oirq;
  logic [7:0] q;
  int mismatches = 0;
  int check_count = 0;

  tc8_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_count_pin_i(ext), .port_data_i(pdat), .wave_output_pin_o(pin),
    .wave_output_pin_oe_o(oe), .compare_vec_taken_i(cvec), .overflow_vec_taken_i(ovec),
    .compare_irq_o(cirq), .overflow_irq_o(oirq));

  // Free-running clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("ERROR at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail($sformatf("got %h expected %h", got, exp));
    end
  endtask
  // One classic cycle; waits for ack, since the slave sets the pace
  task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_use;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    if (n >= 20) begin
      fail("no ack");
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    logic [6:0] idx [6] = '{CT, MK, CN, CP, FL, AX};
    foreach (idx[i]) begin
      rd(idx[i], 8'h00);
    end
    wr(MK, 8'hFF);
    rd(MK, 8'h03);
    wr(7'h10, 8'hFF);
    rd(7'h10, 8'h00);
    wr(MK, 8'h00);
    wr(CN, 8'h5A);
    rd(CN, 8'h5A);
    // Low byte lane off: the write is acked but ignored
    sel_use = 4'h0;
    wr(CN, 8'hA5);
    sel_use = 4'h1;
    rd(CN, 8'h5A);
  endtask
  // Stopped timer: only the strobe can move the wave
  task automatic t_force;
    logic [7:0] cv [5] = '{8'hB8, 8'hA8, 8'h98, 8'h98, 8'hF8};
    logic pv [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    wr(AX, 8'h01);
    wr(CP, 8'h10);
    wr(CN, 8'h33);
    foreach (cv[i]) begin
      wr(CT, cv[i]);
      repeat (3) @(posedge clk_i);
      chk({6'h00, oe, pin}, {6'h00, 1'b1, pv[i]});
    end
    rd(CT, 8'h78);
    rd(CN, 8'h33);
    rd(FL, 8'h00);
    pdat <= 1'b1;
    wr(CT, 8'h08);
    wr(AX, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({6'h00, oe, pin}, 8'h01);
  endtask
  task automatic t_ctc;
    wr(CN, 8'h00);
    wr(CP, 8'h05);
    wr(MK, 8'h02);
    wr(AX, 8'h02);
    wr(CT, 8'h09);
    repeat (40) @(posedge clk_i);
    wr(CT, 8'h08);
    bus(1'b0, CN, 8'h00);
    chk({7'h00, q <= 8'h05}, 8'h01);
    rd(FL, 8'h02);
    chk({7'h00, cirq}, 8'h01);
    wr(FL, 8'h02);
    rd(FL, 8'h00);
  endtask
  // Compare at 01 is passed just after the wrap, so both flags end set
  task automatic t_ovf;
    int n;
    wr(CT, 8'h00);
    wr(CP, 8'h01);
    wr(CN, 8'hF0);
    wr(MK, 8'h01);
    wr(CT, 8'h01);
    n = 0;
    while (oirq !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40) begin
      fail("no overflow request");
    end
    wr(CT, 8'h00);
    rd(FL, 8'h03);
    chk({7'h00, cirq}, 8'h00);
    wr(MK, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({7'h00, oirq}, 8'h00);
    wr(MK, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({7'h00, oirq}, 8'h01);
    ovec <= 1'b1;
    @(posedge clk_i);
    ovec <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({7'h00, oirq}, 8'h00);
    cvec <= 1'b1;
    @(posedge clk_i);
    cvec <= 1'b0;
    rd(FL, 8'h00);
  endtask
  // Pin set as output; its edges still count
  task automatic t_ext;
    wr(AX, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(CT, 8'h00);
      wr(CN, 8'h00);
      wr(CT, k == 0 ? 8'h07 : 8'h06);
      repeat (3) begin
        repeat (4) @(posedge clk_i);
        ext <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext <= 1'b0;
      end
      repeat (6) @(posedge clk_i);
      wr(CT, 8'h00);
      rd(CN, 8'h03);
    end
  endtask
  // Every prescaler tap: four periods plus bus cycles give 4 or 5 ticks
  task automatic t_div8;
    logic [7:0] cs [4] = '{8'h02, 8'h03, 8'h04, 8'h05};
    int div [4] = '{8, 64, 256, 1024};
    foreach (cs[i]) begin
      wr(CN, 8'h00);
      wr(CT, cs[i]);
      repeat (4 * div[i]) @(posedge clk_i);
      wr(CT, 8'h00);
      bus(1'b0, CN, 8'h00);
      chk({7'h00, q >= 8'h04 && q <= 8'h05}, 8'h01);
    end
  endtask
  // Duty measured over whole periods, so phase does not matter
  task automatic t_pwm;
    // Last entry: compare at MAX in phase mode must stay high throughout
    logic [7:0] cfg [5] = '{8'h69, 8'h79, 8'h61, 8'h71, 8'h61};
    logic [7:0] cmp [5] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'hFF};
    int win [5] = '{1024, 1024, 1020, 1020, 1020};
    int exp [5] = '{260, 764, 256, 764, 1020};
    int hi;
    foreach (cfg[i]) begin
      wr(CT, 8'h00);
      wr(CP, cmp[i]);
      wr(CN, 8'h00);
      wr(CT, cfg[i]);
      repeat (520) @(posedge clk_i);
      hi = 0;
      repeat (win[i]) begin
        @(posedge clk_i);
        hi += (pin === 1'b1);
      end
      chk({7'h00, hi > exp[i] - 8 && hi < exp[i] + 8}, 8'h01);
    end
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_force;
    t_ctc;
    t_ovf;
    t_ext;
    t_div8;
    t_pwm;
    report_and_stop;
  end
  // Watchdog, well beyond the expected run
  initial begin
    repeat (30000) @(posedge clk_i);
    fail("timeout");
    report_and_stop;
  end
endmodule
